// ===== pkg/cfg_port_consts.svh
// Offsets, field positions, response codes and timing counts of the access controller.
// Assumes inclusion from the package and the core; definitions only.
`ifndef CFG_PORT_CONSTS_SVH
`define CFG_PORT_CONSTS_SVH
`define CPA_IDX_WFIFO 3'h0
`define CPA_IDX_RFIFO 3'h1
`define CPA_IDX_CTRL 3'h2
`define CPA_IDX_STAT 3'h3
`define CPA_IDX_LEVEL 3'h4
`define CPA_CTRL_START_WR 0
`define CPA_CTRL_START_RD 1
`define CPA_CTRL_RDCNT_LSB 16
`define CPA_CTRL_RDCNT_MSB 31
`define CPA_STAT_BUSY_WR 0
`define CPA_STAT_BUSY_RD 1
`define CPA_STAT_EOS 2
`define CPA_STAT_REQ 3
`define CPA_STAT_GNT 4
`define CPA_RESP_OKAY 2'h0
`define CPA_RESP_SLVERR 2'h2
`define CPA_REL_GAP_CYC 2'd3
`define CPA_PORT_CLK_MHZ_MAX 100
`endif

// ===== pkg/cfg_port_pkg.sv
// Types shared by the access controller and its bench.
// Assumes the constants header sits beside it in pkg/.
`include "cfg_port_consts.svh"
package cfg_port_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_OWN,
		ST_DRAIN,
		ST_WAITREL,
		ST_GAP
	} arb_state_t;
endpackage

// ===== core/config_port_access_controller.sv
// Configuration port access controller: AXI4-Lite slave, write and read buffers,
// port sequencer and request/grant/release handshake.
// Assumes clk is at most 100 MHz and also clocks the port; grant, release and
// end-of-startup arrive from pins; read data stands during the read strobe cycle.
`include "cfg_port_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module config_port_access_controller #(
	parameter int ADDR_W = 5,
	parameter int WR_DEPTH = 128,
	parameter int RD_DEPTH = 128,
	parameter bit EXTERNAL = 1'b1
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic cfg_en,
	output logic cfg_wr,
	output logic [31:0] cfg_wdata,
	input wire logic [31:0] cfg_rdata,
	output logic cap_req,
	input wire logic cap_gnt,
	input wire logic cap_rel,
	input wire logic eos_in
);
	import cfg_port_pkg::*;

	localparam int WA = $clog2(WR_DEPTH);
	localparam int RA = $clog2(RD_DEPTH);

	// Buffer storage, depths fixed when the core is built
	logic [31:0] wmem [WR_DEPTH];
	logic [31:0] rmem [RD_DEPTH];
	logic [WA-1:0] wwp_ff, wrp_ff;
	logic [RA-1:0] rwp_ff, rrp_ff;
	logic [WA:0] wcnt_ff;
	logic [RA:0] rcnt_ff;

	logic gnt_s1_ff, gnt_ff, rel_s1_ff, rel_ff, eos_s1_ff, eos_ff;
	logic gnt_ok, rel_ok, eos_ok;
	arb_state_t st_ff, nxt_st;
	logic [1:0] gap_ff;
	logic op_wr_ff, op_rd_ff, pend_ff;
	logic [15:0] rd_left_ff;
	logic wr_work, rd_need, rd_space, issue, issue_wr, issue_rd;
	logic aw_hs, ar_hs, wf_push, wf_pop, rf_push, rf_pop, ctrl_wr;
	logic [2:0] widx, ridx;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			gnt_s1_ff <= 1'b0;
			gnt_ff <= 1'b0;
			rel_s1_ff <= 1'b0;
			rel_ff <= 1'b0;
			eos_s1_ff <= 1'b0;
			eos_ff <= 1'b0;
		end else begin
			gnt_s1_ff <= cap_gnt;
			gnt_ff <= gnt_s1_ff;
			rel_s1_ff <= cap_rel;
			rel_ff <= rel_s1_ff;
			eos_s1_ff <= eos_in;
			eos_ff <= eos_s1_ff;
		end
	end

	// With the primitive inside, nobody else competes for the port
	assign gnt_ok = EXTERNAL ? gnt_ff : 1'b1;
	assign rel_ok = EXTERNAL ? rel_ff : 1'b0;
	assign eos_ok = EXTERNAL ? eos_ff : 1'b1;

	// Bus slave: address and data are taken together in one handshake
	assign aw_hs = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
	assign ar_hs = s_axi_arready & s_axi_arvalid;
	assign widx = s_axi_awaddr[4:2];
	assign ridx = s_axi_araddr[4:2];
	assign wf_push = aw_hs && widx == `CPA_IDX_WFIFO && wcnt_ff != (WA+1)'(WR_DEPTH);
	assign ctrl_wr = aw_hs && widx == `CPA_IDX_CTRL && !op_wr_ff && !op_rd_ff;
	assign rf_pop = ar_hs && ridx == `CPA_IDX_RFIFO && rcnt_ff != '0;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CPA_RESP_OKAY;
		end else begin
			s_axi_awready <= !s_axi_awready && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
			s_axi_wready <= !s_axi_awready && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
			if (aw_hs) begin
				s_axi_bvalid <= 1'b1;
				// A full write buffer drops the word and says so
				if (widx == `CPA_IDX_WFIFO)
					s_axi_bresp <= wf_push ? `CPA_RESP_OKAY : `CPA_RESP_SLVERR;
				else if (widx == `CPA_IDX_CTRL)
					s_axi_bresp <= `CPA_RESP_OKAY;
				else
					s_axi_bresp <= `CPA_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `CPA_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
			if (ar_hs) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `CPA_RESP_OKAY;
				case (ridx)
					`CPA_IDX_RFIFO: begin
						s_axi_rdata <= rf_pop ? rmem[rrp_ff] : 32'h0;
						if (!rf_pop)
							s_axi_rresp <= `CPA_RESP_SLVERR;
					end
					`CPA_IDX_CTRL: s_axi_rdata <= {rd_left_ff, 14'h0, op_rd_ff, op_wr_ff};
					`CPA_IDX_STAT: s_axi_rdata <= {27'h0, gnt_ok, cap_req, eos_ok, op_rd_ff, op_wr_ff};
					`CPA_IDX_LEVEL: s_axi_rdata <= {16'(wcnt_ff), 16'(rcnt_ff)};
					default: begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= `CPA_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Buffer writes: bus side fills the write buffer, port side fills the read buffer, in the same clock
	always_ff @(posedge clk) begin
		if (wf_push)
			wmem[wwp_ff] <= s_axi_wdata;
		if (rf_push)
			rmem[rwp_ff] <= EXTERNAL ? cfg_rdata : 32'h0;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wwp_ff <= '0;
			wrp_ff <= '0;
			wcnt_ff <= '0;
			rwp_ff <= '0;
			rrp_ff <= '0;
			rcnt_ff <= '0;
		end else begin
			// Simultaneous push and pop leave the level unchanged
			if (wf_push)
				wwp_ff <= wwp_ff + 1'b1;
			if (wf_pop)
				wrp_ff <= wrp_ff + 1'b1;
			wcnt_ff <= wcnt_ff + (WA+1)'(wf_push) - (WA+1)'(wf_pop);
			if (rf_push)
				rwp_ff <= rwp_ff + 1'b1;
			if (rf_pop)
				rrp_ff <= rrp_ff + 1'b1;
			rcnt_ff <= rcnt_ff + (RA+1)'(rf_push) - (RA+1)'(rf_pop);
		end
	end

	// Port sequencer
	assign wr_work = op_wr_ff && wcnt_ff != '0;
	assign rd_need = op_rd_ff && rd_left_ff != 16'h0;
	// Count the word in flight so a full read buffer never overflows
	assign rd_space = (rcnt_ff + (RA+1)'(pend_ff)) < (RA+1)'(RD_DEPTH);
	assign issue = st_ff == ST_OWN && gnt_ok && !rel_ok && eos_ok && (wr_work || (rd_need && rd_space));
	assign issue_wr = issue && wr_work;
	assign issue_rd = issue && !wr_work;
	assign wf_pop = issue_wr;
	assign rf_push = pend_ff;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			op_wr_ff <= 1'b0;
			op_rd_ff <= 1'b0;
			rd_left_ff <= 16'h0;
			pend_ff <= 1'b0;
		end else begin
			pend_ff <= issue_rd;
			if (ctrl_wr) begin
				op_wr_ff <= s_axi_wdata[`CPA_CTRL_START_WR];
				op_rd_ff <= s_axi_wdata[`CPA_CTRL_START_RD];
				rd_left_ff <= s_axi_wdata[`CPA_CTRL_RDCNT_MSB:`CPA_CTRL_RDCNT_LSB];
			end else begin
				if (op_wr_ff && wcnt_ff == (WA+1)'(1) && wf_pop && !wf_push)
					op_wr_ff <= 1'b0;
				else if (op_wr_ff && wcnt_ff == '0 && st_ff == ST_IDLE)
					op_wr_ff <= 1'b0;
				if (issue_rd)
					rd_left_ff <= rd_left_ff - 16'h1;
				if (op_rd_ff && rd_left_ff == 16'h0 && !pend_ff)
					op_rd_ff <= 1'b0;
			end
		end
	end

	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			ST_IDLE: begin
				if ((wr_work || rd_need) && eos_ok && !rel_ok)
					nxt_st = ST_OWN;
			end
			ST_OWN: begin
				if (rel_ok)
					nxt_st = ST_DRAIN;
				else if (!wr_work && !rd_need && !pend_ff)
					nxt_st = ST_IDLE;
			end
			ST_DRAIN: begin
				if (!pend_ff)
					nxt_st = ST_WAITREL;
			end
			ST_WAITREL: begin
				if (!rel_ok)
					nxt_st = ST_GAP;
			end
			ST_GAP: begin
				if (rel_ok)
					nxt_st = ST_WAITREL;
				else if (gap_ff == `CPA_REL_GAP_CYC - 2'd1)
					nxt_st = ST_IDLE;
			end
			default: nxt_st = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_ff <= ST_IDLE;
			gap_ff <= 2'd0;
			cap_req <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			gap_ff <= (st_ff == ST_GAP && nxt_st == ST_GAP) ? gap_ff + 2'd1 : 2'd0;
			// Held through ownership and draining so the request has no gaps
			cap_req <= EXTERNAL && (nxt_st == ST_OWN || nxt_st == ST_DRAIN);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg_en <= 1'b0;
			cfg_wr <= 1'b0;
			cfg_wdata <= 32'h0;
		end else begin
			// Boundary strobes stay quiet when the primitive lives inside
			cfg_en <= EXTERNAL && issue;
			cfg_wr <= EXTERNAL && issue_wr;
			cfg_wdata <= (EXTERNAL && issue_wr) ? wmem[wrp_ff] : 32'h0;
		end
	end
endmodule
`default_nettype wire

// ===== bench/config_port_access_controller_chk.sv
// Bus and port handshake assertions for the access controller.
// Assumes binding onto the top module, with one clock and an active-low reset.
`timescale 1ns/1ps
`default_nettype none
module config_port_access_controller_chk (
	input wire logic clk,
	input wire logic rstn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic cfg_en,
	input wire logic cfg_wr,
	input wire logic cap_req,
	input wire logic cap_gnt,
	input wire logic cap_rel
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	a_bresp_follows: assert property (
		s_axi_awready && s_axi_awvalid && s_axi_wvalid |=> s_axi_bvalid) else $error("no bvalid");
	a_bresp_holds: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b drop");
	a_rdata_follows: assert property (
		s_axi_arready && s_axi_arvalid |=> s_axi_rvalid) else $error("no rvalid");
	a_rdata_holds: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r drop");
	// Pins pass two flops and the strobe one more, so the pin is seen three edges back
	a_strobe_owned: assert property (
		cfg_en |-> cap_req && $past(cap_gnt, 3)) else $error("strobe without grant");
	a_strobe_released: assert property (
		cfg_en |-> !$past(cap_rel, 3)) else $error("strobe during release");
	a_req_release: assert property (
		$rose(cap_rel) |-> ##[1:16] !cap_req) else $error("request kept after release");
	a_gap_release: assert property (
		$fell(cap_rel) && !cap_req |=> !cap_req [*3]) else $error("request too soon");
	c_write_word: cover property (cfg_en && cfg_wr);
	c_read_word: cover property (cfg_en && !cfg_wr);
	c_release_end: cover property ($fell(cap_rel));
endmodule
bind config_port_access_controller config_port_access_controller_chk chk (.clk, .rstn,
	.s_axi_awvalid, .s_axi_wvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
	.cfg_en, .cfg_wr, .cap_req, .cap_gnt, .cap_rel);
`default_nettype wire

// ===== bench/cap_arbiter_model.sv
// Port arbiter and configuration port stand-in for the bench.
// Assumes the controller's clock; grant delay and release come from the bench.
`timescale 1ns/1ps
`default_nettype none
module cap_arbiter_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic cap_req,
	input wire logic cfg_en,
	input wire logic cfg_wr,
	input wire logic rel_cmd,
	input wire logic [3:0] gnt_delay,
	output logic cap_gnt,
	output logic cap_rel,
	output logic [31:0] cfg_rdata
);
	logic [3:0] wait_ff;
	logic [31:0] word_ff;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cap_gnt <= 1'b0;
			wait_ff <= 4'h0;
		end else if (!cap_req) begin
			cap_gnt <= 1'b0;
			wait_ff <= 4'h0;
		end else if (wait_ff == gnt_delay) begin
			cap_gnt <= 1'b1;
		end else begin
			wait_ff <= wait_ff + 4'h1;
		end
	end
	// Release stays up until the request is gone, so it is never withdrawn mid-transfer
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) cap_rel <= 1'b0;
		else cap_rel <= rel_cmd || (cap_rel && cap_req);
	end
	// The controller stores the word at the edge that ends its read strobe,
	// so the answer stands while the strobe is high
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			word_ff <= 32'h0;
		else if (cfg_en && !cfg_wr)
			word_ff <= word_ff + 32'h1;
	end
	// Outside the strobe cycle the word is inverted so a stale sample shows up
	always_comb begin
		cfg_rdata = (cfg_en && !cfg_wr) ? 32'hC0DE0000 + word_ff : ~(32'hC0DE0000 + word_ff);
	end
endmodule
`default_nettype wire

// ===== bench/config_port_access_controller_tb.sv
// Self-checking bench for the access controller.
// Assumes the arbiter model and the bound checker; inputs change on falling edges.
`include "cfg_port_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module config_port_access_controller_tb;
	import cfg_port_pkg::*;
	logic clk = 0, rstn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, rel_cmd = 0;
	logic [4:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, cfg_wdata, cfg_rdata, wq[$];
	logic awready, wready, bvalid, arready, rvalid, cfg_en, cfg_wr, cap_req, cap_gnt, cap_rel;
	logic [1:0] bresp, rresp;
	logic [3:0] gnt_delay = 0;
	logic eos = 1;
	int err_count = 0, checks_done = 0, cyc = 0;
	always #5 clk = ~clk;
	config_port_access_controller #(.WR_DEPTH(4), .RD_DEPTH(4)) uut (.clk, .rstn,
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.cfg_en, .cfg_wr, .cfg_wdata, .cfg_rdata, .cap_req, .cap_gnt, .cap_rel, .eos_in(eos));
	cap_arbiter_model arb (.clk, .rstn, .cap_req, .cfg_en, .cfg_wr, .rel_cmd, .gnt_delay,
		.cap_gnt, .cap_rel, .cfg_rdata);
	always @(posedge clk) if (cfg_en === 1'b1 && cfg_wr === 1'b1) wq.push_back(cfg_wdata);
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			conclude();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
		int n = 0;
		@(negedge clk);
		awaddr = a;
		wdata = d;
		awv = 1;
		wv = 1;
		while (awready !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		check("wready", wready, 1);
		@(negedge clk);
		awv = 0;
		wv = 0;
		@(negedge clk);
		check("bvalid", bvalid, 1);
		check("bresp", bresp, r);
		bready = 1;
		@(negedge clk);
		bready = 0;
	endtask
	task automatic axi_rd(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
		int n = 0;
		@(negedge clk);
		araddr = a;
		arv = 1;
		while (arready !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		arv = 0;
		@(negedge clk);
		check("rvalid", rvalid, 1);
		check("rdata", rdata, d);
		check("rresp", rresp, r);
		rready = 1;
		@(negedge clk);
		rready = 0;
	endtask
	task automatic wait_req(input logic lvl, output int n);
		n = 0;
		while (cap_req !== lvl && n < 60) begin
			@(negedge clk);
			n++;
		end
	endtask
	task automatic t_unmapped;
		check("req idle", cap_req, 0);
		axi_wr(5'h14, 32'h0, `CPA_RESP_SLVERR);
		axi_rd(5'h1C, 32'h0, `CPA_RESP_SLVERR);
		axi_rd(5'h0C, 32'h4, `CPA_RESP_OKAY);
		check("req still idle", cap_req, 0);
	endtask
	task automatic t_write;
		int n;
		for (int i = 0; i < 5; i++) axi_wr(5'h00, 32'hA5000000 + i, (i < 4) ? 2'h0 : 2'h2);
		axi_wr(5'h08, 32'h1, `CPA_RESP_OKAY);
		wait_req(1, n);
		wait_req(0, n);
		check("words", wq.size(), 4);
		for (int i = 0; i < 4; i++) check("word", wq[i], 32'hA5000000 + i);
	endtask
	task automatic t_read;
		int n;
		gnt_delay = 3;
		eos = 0;
		axi_wr(5'h08, 32'h00030002, `CPA_RESP_OKAY);
		// Start-up not finished: the read is pending but the port is not asked for
		axi_rd(5'h0C, 32'h2, `CPA_RESP_OKAY);
		check("req before eos", cap_req, 0);
		eos = 1;
		wait_req(1, n);
		check("req after eos", cap_req, 1);
		wait_req(0, n);
		for (int i = 0; i < 3; i++) axi_rd(5'h04, 32'hC0DE0000 + i, `CPA_RESP_OKAY);
		axi_rd(5'h04, 32'h0, `CPA_RESP_SLVERR);
	endtask
	task automatic t_release;
		int n;
		gnt_delay = 8;
		axi_wr(5'h00, 32'h5A5A0001, `CPA_RESP_OKAY);
		axi_wr(5'h08, 32'h1, `CPA_RESP_OKAY);
		wait_req(1, n);
		rel_cmd = 1;
		wait_req(0, n);
		check("req dropped", cap_req, 0);
		check("held words", wq.size(), 4);
		rel_cmd = 0;
		wait_req(1, n);
		check("gap kept", n > 3, 1);
		wait_req(0, n);
		check("resumed", wq.size(), 5);
		check("late word", wq[4], 32'h5A5A0001);
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(negedge clk);
		rstn = 1;
		t_unmapped();
		t_write();
		t_read();
		t_release();
		conclude();
	end
endmodule
`default_nettype wire
